// ===== shared/clock_watchdog_cfg.svh
// constants and field layout of the clock watchdog and output control bytes
`ifndef CLOCK_WATCHDOG_CFG_SVH
`define CLOCK_WATCHDOG_CFG_SVH
`define CLK_HZ 10000000
`define OFS_TIMEOUT 8'h08
`define OFS_CONTROL 8'h09
`define OFS_SKEW 8'h0a
`define OFS_RECOVERY_N 8'h0b
`define RST_TIMEOUT 8'h3e
`define RST_CONTROL 8'h00
`define RST_SKEW 8'h00
`define RST_RECOVERY_N 8'h00
`define TMO_TICK_SEL_BIT 0
`define TMO_COUNT_LSB 1
`define TMO_COUNT_MSB 5
`define CTL_USB_DRV_BIT 7
`define CTL_BUS_DRV_BIT 6
`define CTL_MID_DRV_BIT 5
`define CTL_RST_EXP_BIT 4
`define CTL_RST_RETUNE_BIT 3
`define CTL_EXPIRY_BIT 2
`define CTL_RUN_BIT 1
`define SKW_CPU_LSB 5
`define SKW_CPU_MSB 7
`define SKW_FIXED_BIT 4
`define SKW_BUS_LSB 2
`define SKW_BUS_MSB 3
`define SKW_MID_LSB 0
`define SKW_MID_MSB 1
`define CPU_SKEW_STEP_PS 150
`define BUS_SKEW_STEP_PS 500
`define MID_SKEW_STEP_PS 150
`define FIXED_MID_MHZ 7'h40
`define FIXED_BUS_MHZ 7'h20
`define SHORT_STEP_MS 150
`define LONG_STEP_MS 2500
`define SHORT_STEP_CYC (`SHORT_STEP_MS * (`CLK_HZ / 1000))
`define LONG_STEP_CYC (`LONG_STEP_MS * (`CLK_HZ / 1000))
`define RST_PULSE_NS 1000
`define RST_PULSE_CYC (`RST_PULSE_NS / (1000000000 / `CLK_HZ))
`endif

// ===== shared/clock_watchdog_pkg.sv
// types shared by the clock watchdog modules
package clock_watchdog_pkg;
	// gray order along idle, armed, counting, locked
	typedef enum logic [1:0] {
		WD_IDLE = 2'h0,
		WD_ARMED = 2'h1,
		WD_COUNT = 2'h3,
		WD_LOCKED = 2'h2
	} wd_state_e;
	typedef logic [7:0] byte_t;
	typedef logic signed [10:0] skew_ps_t;
endpackage

// ===== shared/wd_ctrl_if.sv
// signals between the watchdog core, its prescaler and its reset stretcher
`timescale 1ns/100ps
interface wd_ctrl_if;
	logic tick_run;
	logic tick_long;
	logic tick;
	logic pulse_fire;
	logic pulse_active;
	modport core (output tick_run, output tick_long, output pulse_fire,
		input tick, input pulse_active);
	modport divider (input tick_run, input tick_long, output tick);
	modport stretcher (input pulse_fire, output pulse_active);
endinterface

// ===== hw/prescale_tick.sv
// prescaler giving one-cycle watchdog step pulses
`timescale 1ns/100ps
module prescale_tick
	import clock_watchdog_pkg::*;
#(
	parameter int unsigned SHORT_CYC = 1500000,
	parameter int unsigned LONG_CYC = 25000000
)
(
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	wd_ctrl_if.divider ctl
);
	logic [24:0] div_q;
	logic [24:0] limit;
	logic tick_q;

	// period end for the selected step
	assign limit = ctl.tick_long ? 25'(LONG_CYC - 1) : 25'(SHORT_CYC - 1);
	assign ctl.tick = tick_q;

	// divider restarts whenever the watchdog is not counting
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			div_q <= 25'h0;
			tick_q <= 1'b0;
		end
		else if (!ctl.tick_run)
		begin
			div_q <= 25'h0;
			tick_q <= 1'b0;
		end
		else if (div_q >= limit)
		begin
			div_q <= 25'h0;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 25'h1;
			tick_q <= 1'b0;
		end
	end
endmodule // prescale_tick

// ===== hw/reset_stretch.sv
// stretches a reset request into a fixed-width system reset pulse
`timescale 1ns/100ps
module reset_stretch
	import clock_watchdog_pkg::*;
#(
	parameter logic [7:0] WIDTH_CYC = 8'h0a
)
(
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	wd_ctrl_if.stretcher ctl
);
	logic [7:0] left_q;

	assign ctl.pulse_active = (left_q != 8'h0);

	// a new request restarts the full width
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			left_q <= 8'h0;
		else if (ctl.pulse_fire)
			left_q <= WIDTH_CYC;
		else if (left_q != 8'h0)
			left_q <= left_q - 8'h1;
	end
endmodule // reset_stretch

// ===== hw/clock_watchdog_recovery.sv
// watchdog, recovery lock and output control bytes of the clock synthesizer
`timescale 1ns/100ps
`include "clock_watchdog_cfg.svh"
module clock_watchdog_recovery
	import clock_watchdog_pkg::*;
#(
	parameter int unsigned SHORT_STEP_CYC = `SHORT_STEP_CYC,
	parameter int unsigned LONG_STEP_CYC = `LONG_STEP_CYC
)
(
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] bus_addr_in,
	input wire logic bus_wr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_rd_in,
	output logic [7:0] bus_rdata_out,
	output logic bus_rvalid_out,
	input wire logic freq_change_in,
	input wire logic freq_write_req_in,
	output logic freq_write_accept_out,
	input wire logic recovery_source_select_in,
	input wire logic strap_override_in,
	input wire logic [4:0] strap_frequency_select_in,
	input wire logic [4:0] sw_frequency_select_in,
	input wire logic [6:0] mid_rate_nominal_mhz_in,
	input wire logic [6:0] bus_clock_nominal_mhz_in,
	output logic sys_reset_out,
	output logic recovery_load_out,
	output logic recovery_locked_out,
	output logic recovery_use_programmed_out,
	output logic [7:0] recovery_feedback_count_out,
	output logic [4:0] freq_ratio_select_out,
	output logic usb_clock_drive_out,
	output logic bus_clock_drive_out,
	output logic mid_rate_clock_drive_out,
	output logic fixed_output_rate_mode_out,
	output logic [6:0] mid_rate_clock_mhz_out,
	output logic [6:0] bus_clock_mhz_out,
	output logic signed [10:0] cpu_skew_ps_out,
	output logic signed [10:0] bus_clock_skew_ps_out,
	output logic signed [10:0] mid_rate_clock_skew_ps_out
);
	wd_ctrl_if ctl ();

	byte_t timeout_q;
	byte_t skew_q;
	byte_t recovery_n_q;
	logic [4:0] ctl_bits_q;
	logic expiry_flag_q;
	logic watchdog_run_q;
	wd_state_e state_q;
	logic [4:0] count_q;
	logic expire;
	logic exp_fire;
	logic retune_fire;
	logic wr_timeout;
	logic wr_control;
	logic [4:0] reload;
	logic [2:0] cpu_code;
	logic [1:0] bus_code;
	logic [1:0] mid_code;

	assign wr_timeout = bus_wr_in && (bus_addr_in == `OFS_TIMEOUT);
	assign wr_control = bus_wr_in && (bus_addr_in == `OFS_CONTROL);
	assign reload = timeout_q[`TMO_COUNT_MSB:`TMO_COUNT_LSB];
	assign cpu_code = skew_q[`SKW_CPU_MSB:`SKW_CPU_LSB];
	assign bus_code = skew_q[`SKW_BUS_MSB:`SKW_BUS_LSB];
	assign mid_code = skew_q[`SKW_MID_MSB:`SKW_MID_LSB];

	// count reaches zero on the step that leaves one; a loaded zero wraps to 32 steps
	assign expire = (state_q == WD_COUNT) && watchdog_run_q && ctl.tick
		&& (count_q == 5'h1);

	// prescaler runs only while counting, step length from bit 0
	assign ctl.tick_run = (state_q == WD_COUNT);
	assign ctl.tick_long = timeout_q[`TMO_TICK_SEL_BIT];

	// reset on expiry and reset after retune, each gated by its enable
	assign exp_fire = expire && ctl_bits_q[`CTL_RST_EXP_BIT - 3];
	assign retune_fire = freq_change_in && ctl_bits_q[`CTL_RST_RETUNE_BIT - 3];
	assign ctl.pulse_fire = exp_fire || retune_fire;
	assign sys_reset_out = ctl.pulse_active;

	// frequency change requests refused while locked
	assign freq_write_accept_out = freq_write_req_in && (state_q != WD_LOCKED);

	prescale_tick #(
		.SHORT_CYC(SHORT_STEP_CYC),
		.LONG_CYC(LONG_STEP_CYC)
	) prescale_tick_i (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.ctl(ctl)
	);

	reset_stretch #(
		.WIDTH_CYC(8'(`RST_PULSE_CYC))
	) reset_stretch_i (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.ctl(ctl)
	);

	// time-out byte, top two bits reserved
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			timeout_q <= `RST_TIMEOUT;
		else if (wr_timeout)
			timeout_q <= {2'h0, bus_wdata_in[5:0]};
	end

	// drive and reset enables in control bits 7 to 3
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ctl_bits_q <= 5'(`RST_CONTROL >> 3);
			watchdog_run_q <= 1'b0;
		end
		else if (wr_control)
		begin
			ctl_bits_q <= bus_wdata_in[7:3];
			watchdog_run_q <= bus_wdata_in[`CTL_RUN_BIT];
		end
	end

	// sticky expiry flag, a new expiry beats a clear in the same cycle
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			expiry_flag_q <= 1'b0;
		else if (expire)
			expiry_flag_q <= 1'b1;
		else if (wr_control && bus_wdata_in[`CTL_EXPIRY_BIT])
			expiry_flag_q <= 1'b0;
	end

	// skew and fixed-rate byte, recovery feedback byte
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			skew_q <= `RST_SKEW;
			recovery_n_q <= `RST_RECOVERY_N;
		end
		else if (bus_wr_in)
		begin
			if (bus_addr_in == `OFS_SKEW)
				skew_q <= bus_wdata_in;
			if (bus_addr_in == `OFS_RECOVERY_N)
				recovery_n_q <= bus_wdata_in;
		end
	end

	// watchdog sequence: idle, armed, counting, locked
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			state_q <= WD_IDLE;
		else if (!watchdog_run_q)
			state_q <= WD_IDLE;
		else
		begin
			case (state_q)
				WD_IDLE:
					state_q <= WD_ARMED;
				WD_ARMED:
					if (freq_change_in)
						state_q <= WD_COUNT;
				WD_COUNT:
					if (expire)
						state_q <= WD_LOCKED;
				WD_LOCKED:
					state_q <= WD_LOCKED;
				default:
					state_q <= WD_IDLE;
			endcase
		end
	end

	// down counter, reloaded whenever not counting
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			count_q <= 5'(`RST_TIMEOUT >> `TMO_COUNT_LSB);
		else if (!watchdog_run_q || state_q != WD_COUNT)
			count_q <= reload;
		else if (ctl.tick)
			count_q <= count_q - 5'h1;
	end

	// recovery load pulse and lock indication
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			recovery_load_out <= 1'b0;
			recovery_locked_out <= 1'b0;
		end
		else
		begin
			recovery_load_out <= expire;
			recovery_locked_out <= watchdog_run_q && (expire || state_q == WD_LOCKED);
		end
	end

	// frequency sources for operation and for recovery
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			recovery_use_programmed_out <= 1'b0;
			recovery_feedback_count_out <= 8'h0;
			freq_ratio_select_out <= 5'h0;
		end
		else
		begin
			recovery_use_programmed_out <= recovery_source_select_in;
			recovery_feedback_count_out <= recovery_n_q;
			freq_ratio_select_out <= strap_override_in ? sw_frequency_select_in
				: strap_frequency_select_in;
		end
	end

	// drive strengths and fixed output rates
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			usb_clock_drive_out <= 1'b0;
			bus_clock_drive_out <= 1'b0;
			mid_rate_clock_drive_out <= 1'b0;
			fixed_output_rate_mode_out <= 1'b0;
			mid_rate_clock_mhz_out <= 7'h0;
			bus_clock_mhz_out <= 7'h0;
		end
		else
		begin
			usb_clock_drive_out <= ctl_bits_q[`CTL_USB_DRV_BIT - 3];
			bus_clock_drive_out <= ctl_bits_q[`CTL_BUS_DRV_BIT - 3];
			mid_rate_clock_drive_out <= ctl_bits_q[`CTL_MID_DRV_BIT - 3];
			fixed_output_rate_mode_out <= skew_q[`SKW_FIXED_BIT];
			mid_rate_clock_mhz_out <= skew_q[`SKW_FIXED_BIT] ? `FIXED_MID_MHZ
				: mid_rate_nominal_mhz_in;
			bus_clock_mhz_out <= skew_q[`SKW_FIXED_BIT] ? `FIXED_BUS_MHZ
				: bus_clock_nominal_mhz_in;
		end
	end

	// skew codes turned into signed picosecond shifts
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cpu_skew_ps_out <= 11'sh0;
			bus_clock_skew_ps_out <= 11'sh0;
			mid_rate_clock_skew_ps_out <= 11'sh0;
		end
		else
		begin
			if (cpu_code[2])
				cpu_skew_ps_out <= skew_ps_t'((int'(cpu_code) - 3) * `CPU_SKEW_STEP_PS);
			else
				cpu_skew_ps_out <= skew_ps_t'(-(int'(cpu_code) * `CPU_SKEW_STEP_PS));
			case (bus_code)
				2'h1: bus_clock_skew_ps_out <= skew_ps_t'(-`BUS_SKEW_STEP_PS);
				2'h3: bus_clock_skew_ps_out <= skew_ps_t'(`BUS_SKEW_STEP_PS);
				default: bus_clock_skew_ps_out <= 11'sh0;
			endcase
			case (mid_code)
				2'h1: mid_rate_clock_skew_ps_out <= skew_ps_t'(-`MID_SKEW_STEP_PS);
				2'h2: mid_rate_clock_skew_ps_out <= skew_ps_t'(`MID_SKEW_STEP_PS);
				2'h3: mid_rate_clock_skew_ps_out <= skew_ps_t'(2 * `MID_SKEW_STEP_PS);
				default: mid_rate_clock_skew_ps_out <= 11'sh0;
			endcase
		end
	end

	// register read port, unmapped bytes read zero
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			bus_rdata_out <= 8'h0;
			bus_rvalid_out <= 1'b0;
		end
		else
		begin
			bus_rvalid_out <= bus_rd_in;
			if (bus_rd_in)
			begin
				case (bus_addr_in)
					`OFS_TIMEOUT: bus_rdata_out <= timeout_q;
					`OFS_CONTROL: bus_rdata_out <= {ctl_bits_q, expiry_flag_q,
						watchdog_run_q, 1'b0};
					`OFS_SKEW: bus_rdata_out <= skew_q;
					`OFS_RECOVERY_N: bus_rdata_out <= recovery_n_q;
					default: bus_rdata_out <= 8'h0;
				endcase
			end
		end
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	flag_on_expiry_a: assert property (expire |=> expiry_flag_q)
		else $error("expiry flag not set after expiry");
	expiry_reset_a: assert property (expire && ctl_bits_q[1] |=> sys_reset_out)
		else $error("no reset after enabled expiry");
	reset_cause_a: assert property ($rose(sys_reset_out) |->
		$past(exp_fire) || $past(retune_fire))
		else $error("reset pulse without enabled cause");
	retune_reset_a: assert property (freq_change_in && ctl_bits_q[0]
		|=> sys_reset_out [*5])
		else $error("retune reset missing or short");
	flag_clear_a: assert property (wr_control && bus_wdata_in[2] && !expire
		|=> !expiry_flag_q)
		else $error("expiry flag not cleared by write of one");
	stop_reload_a: assert property (!watchdog_run_q |=>
		state_q == WD_IDLE && count_q == $past(reload))
		else $error("stopped watchdog not idle and reloaded");
	armed_wait_a: assert property (state_q == WD_ARMED && watchdog_run_q
		&& !freq_change_in |=> state_q == WD_ARMED)
		else $error("counting began without frequency change");
	expiry_lock_a: assert property (expire |=> state_q == WD_LOCKED
		&& recovery_load_out && recovery_locked_out)
		else $error("expiry did not lock recovery");
	locked_refuse_a: assert property (state_q == WD_LOCKED |-> !freq_write_accept_out)
		else $error("frequency write accepted while locked");
	unlock_run_a: assert property (state_q == WD_LOCKED && !watchdog_run_q
		|=> state_q == WD_IDLE ##1 !recovery_locked_out)
		else $error("clearing run did not unlock");
	count_step_a: assert property (state_q == WD_COUNT && watchdog_run_q && ctl.tick
		&& count_q != 5'h1 |=> count_q == $past(count_q) - 5'h1)
		else $error("count did not step by one");
	fixed_rate_a: assert property (skew_q[4] |=> mid_rate_clock_mhz_out == 7'h40
		&& bus_clock_mhz_out == 7'h20)
		else $error("fixed rates not held");
endmodule // clock_watchdog_recovery

// ===== tb/reset_sink.sv
// system reset sink that tallies pulses and measures their width
`timescale 1ns/100ps
module reset_sink
(
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic sys_reset_in,
	output int pulses_out,
	output int width_out
);
	int run_q;
	// width counter, tally taken at the falling end of each pulse
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			run_q <= 0;
			pulses_out <= 0;
			width_out <= 0;
		end
		else if (sys_reset_in === 1'b1)
			run_q <= run_q + 1;
		else if (run_q != 0)
		begin
			pulses_out <= pulses_out + 1;
			width_out <= run_q;
			run_q <= 0;
		end
	end
endmodule // reset_sink

// ===== tb/clock_watchdog_recovery_bench.sv
// self-checking bench for the clock watchdog and output control bytes
`timescale 1ns/100ps
module clock_watchdog_recovery_bench;
	import clock_watchdog_pkg::*;
	localparam int S = 20;
	localparam int L = 50;
	logic ref_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, fb_n;
	logic wr = 1'b0, rd = 1'b0, fc = 1'b0, fw_req = 1'b0, rss = 1'b0, so = 1'b0;
	logic rvalid, fw_acc, sys_rst, load, locked, use_prog, usb_drv, bus_drv, mid_drv, fixed;
	logic [4:0] strap = 5'h05, sw = 5'h1a, ratio;
	logic [6:0] mid_mhz, bus_mhz;
	logic [1:0] bc;
	logic signed [10:0] cpu_sk, bus_sk, mid_sk, e_cpu, e_bus, e_mid;
	int num_errors = 0, comparisons = 0, loads = 0, pulses, width, n;
	// free-running reference clock
	always #50 ref_clk_in = ~ref_clk_in;
	clock_watchdog_recovery #(.SHORT_STEP_CYC(S), .LONG_STEP_CYC(L)) clock_watchdog_recovery_i (
		.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .bus_addr_in(addr), .bus_wr_in(wr),
		.bus_wdata_in(wdata), .bus_rd_in(rd), .bus_rdata_out(rdata), .bus_rvalid_out(rvalid),
		.freq_change_in(fc), .freq_write_req_in(fw_req), .freq_write_accept_out(fw_acc),
		.recovery_source_select_in(rss), .strap_override_in(so),
		.strap_frequency_select_in(strap), .sw_frequency_select_in(sw),
		.mid_rate_nominal_mhz_in(7'h21), .bus_clock_nominal_mhz_in(7'h11),
		.sys_reset_out(sys_rst), .recovery_load_out(load), .recovery_locked_out(locked),
		.recovery_use_programmed_out(use_prog), .recovery_feedback_count_out(fb_n),
		.freq_ratio_select_out(ratio), .usb_clock_drive_out(usb_drv),
		.bus_clock_drive_out(bus_drv), .mid_rate_clock_drive_out(mid_drv),
		.fixed_output_rate_mode_out(fixed), .mid_rate_clock_mhz_out(mid_mhz),
		.bus_clock_mhz_out(bus_mhz), .cpu_skew_ps_out(cpu_sk),
		.bus_clock_skew_ps_out(bus_sk), .mid_rate_clock_skew_ps_out(mid_sk));
	reset_sink reset_sink_i (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
		.sys_reset_in(sys_rst), .pulses_out(pulses), .width_out(width));
	// recovery load pulse tally
	always @(posedge ref_clk_in)
		if (load === 1'b1)
			loads++;
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] seen);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
	endtask
	task automatic rd_b(input logic [7:0] a, input logic [7:0] e);
		cyc(1);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		chk("rvalid", 11'h001, {10'h000, rvalid});
		chk("rdata", {3'h0, e}, {3'h0, rdata});
	endtask
	task automatic retune();
		cyc(1);
		fc = 1'b1;
		cyc(1);
		fc = 1'b0;
	endtask
	task automatic wait_lock(input int lo, input int hi);
		n = 0;
		while (locked !== 1'b1 && n < 700)
		begin
			cyc(1);
			n++;
		end
		chk("lock_delay_ok", 11'h001, {10'h000, n >= lo && n <= hi});
	endtask
	task automatic final_report();
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard
	initial
	begin
		#5000000;
		num_errors++;
		final_report();
	end
	// main sequence
	initial
	begin
		repeat (4) @(posedge ref_clk_in);
		#1;
		arst_n_in = 1'b1;
		rd_b(8'h08, 8'h3e);
		rd_b(8'h09, 8'h00);
		rd_b(8'h0a, 8'h00);
		rd_b(8'h0b, 8'h00);
		wr_b(8'h20, 8'hff);
		rd_b(8'h20, 8'h00);
		wr_b(8'h08, 8'hff);
		rd_b(8'h08, 8'h3f);
		wr_b(8'h09, 8'he0);
		cyc(1);
		chk("drives", 11'h007, {8'h00, usb_drv, bus_drv, mid_drv});
		rd_b(8'h09, 8'he0);
		wr_b(8'h09, 8'h40);
		cyc(1);
		chk("drives", 11'h002, {8'h00, usb_drv, bus_drv, mid_drv});
		// every cpu and mid skew code, bus skew codes 0, 1 and 3, fixed rate toggled
		for (int i = 0; i < 8; i++)
		begin
			bc = (i[1:0] == 2'h2) ? 2'h3 : i[1:0];
			wr_b(8'h0a, {i[2:0], i[0], bc, i[1:0]});
			cyc(1);
			e_cpu = (i == 0) ? 11'sd0 : (i < 4) ? 11'(-150 * i) : 11'(150 * (i - 3));
			e_bus = (bc == 2'h0) ? 11'sd0 : (bc == 2'h1) ? -11'sd500 : 11'sd500;
			e_mid = (i[1:0] == 2'h0) ? 11'sd0 : (i[1:0] == 2'h1) ? -11'sd150 : 11'(150 * (i % 4 - 1));
			chk("cpu_skew", e_cpu, cpu_sk);
			chk("bus_skew", e_bus, bus_sk);
			chk("mid_skew", e_mid, mid_sk);
			chk("fixed", {10'h000, i[0]}, {10'h000, fixed});
			chk("mid_mhz", i[0] ? 11'h040 : 11'h021, {4'h0, mid_mhz});
			chk("bus_mhz", i[0] ? 11'h020 : 11'h011, {4'h0, bus_mhz});
			rd_b(8'h0a, {i[2:0], i[0], bc, i[1:0]});
		end
		wr_b(8'h0b, 8'ha5);
		rss = 1'b1;
		so = 1'b1;
		cyc(2);
		chk("feedback_n", 11'h0a5, {3'h0, fb_n});
		chk("use_prog", 11'h001, {10'h000, use_prog});
		chk("ratio", 11'h01a, {6'h00, ratio});
		rss = 1'b0;
		so = 1'b0;
		cyc(2);
		chk("use_prog", 11'h000, {10'h000, use_prog});
		chk("ratio", 11'h005, {6'h00, ratio});
		// reset after frequency change, enabled then disabled
		wr_b(8'h09, 8'h08);
		retune();
		cyc(15);
		chk("pulses", 11'h001, 11'(pulses));
		chk("width", 11'h00a, 11'(width));
		wr_b(8'h09, 8'h00);
		retune();
		cyc(15);
		chk("pulses", 11'h001, 11'(pulses));
		// short step expiry with reset enabled
		wr_b(8'h08, 8'h04);
		wr_b(8'h09, 8'h12);
		cyc(100);
		chk("armed_idle", 11'h000, {10'h000, locked});
		retune();
		wait_lock(2 * S - 2, 2 * S + 6);
		cyc(15);
		chk("pulses", 11'h002, 11'(pulses));
		chk("width", 11'h00a, 11'(width));
		chk("loads", 11'h001, 11'(loads));
		fw_req = 1'b1;
		#1;
		chk("accept", 11'h000, {10'h000, fw_acc});
		rd_b(8'h09, 8'h16);
		wr_b(8'h09, 8'h12);
		rd_b(8'h09, 8'h16);
		chk("locked", 11'h001, {10'h000, locked});
		wr_b(8'h09, 8'h10);
		cyc(2);
		chk("locked", 11'h000, {10'h000, locked});
		chk("accept", 11'h001, {10'h000, fw_acc});
		rd_b(8'h09, 8'h14);
		wr_b(8'h09, 8'h14);
		rd_b(8'h09, 8'h10);
		fw_req = 1'b0;
		// long step: stop mid count, then full reload and silent expiry
		wr_b(8'h08, 8'h03);
		wr_b(8'h09, 8'h02);
		retune();
		cyc(L / 2);
		wr_b(8'h09, 8'h00);
		cyc(3 * L);
		chk("stopped", 11'h000, {10'h000, locked});
		wr_b(8'h09, 8'h02);
		retune();
		wait_lock(L - 2, L + 6);
		cyc(15);
		chk("pulses", 11'h002, 11'(pulses));
		chk("loads", 11'h002, 11'(loads));
		// loaded zero wraps to the longest span of 32 short steps
		wr_b(8'h09, 8'h00);
		wr_b(8'h08, 8'h00);
		wr_b(8'h09, 8'h02);
		retune();
		wait_lock(32 * S - 2, 32 * S + 6);
		cyc(2);
		chk("pulses", 11'h002, 11'(pulses));
		chk("loads", 11'h003, 11'(loads));
		final_report();
	end
endmodule // clock_watchdog_recovery_bench
